// ### can_irq_fifo_status_regs.sv
// interrupt, fifo and filter-status registers of a can controller.
// assumes avalon-mm master on ref_clk and engine pulses synchronous to it.
// What this block does
// - read-only 5-bit data-byte filter count
// - zero or codes 10010+ compare no bytes
// - matched filter number, 0 to 15 only
// - fixed codes for fifo, overflow, wakeup, error
// - buffer interrupt code equals buffer number
// - buffer-size code selects dma buffer count
// - writable fifo start buffer 0 to 31
// - read-only fifo write pointer
// - read-only fifo next-read pointer
// - bit 13 shows transmitter bus-off
// - bits 12, 11 show error-passive states
// - warning bits 10, 9 and combined 8
// - error flag set on new error state
// - invalid-message flag bit 7, software clear
// - wake-up flag bit 6, clear only
// - fifo almost-full flag bit 3
// - receive overflow flag bit 2
// - buffer flags bits 1, 0; bit 4 zero
// - enable bits match flags, reset zero
// - mode change waits for eleven recessive bits
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`include "can_irq_params.svh"
`timescale 1ns/1ns
`default_nettype none

module can_irq_fifo_status_regs (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic [4:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [3:0]            byteenable,
    input  wire logic [31:0]           writedata,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    input  wire can_irq_pkg::err_state_t err_state,
    input  wire can_irq_pkg::event_t   events,
    input  wire logic [4:0]            filter_bit_count_in,
    input  wire logic                  bit_tick,
    input  wire logic                  bus_recessive,
    output logic                       irq,
    output logic [4:0]                 filter_data_bits,
    output logic [4:0]                 fifo_write_pointer,
    output logic [2:0]                 current_mode
);

    // next fifo pointer: wraps to the start once past the dma area
    function automatic logic [5:0] ptr_next(input logic [5:0] p,
                                            input logic [5:0] cnt,
                                            input logic [4:0] st);
        logic [5:0] inc;
        inc = p + 6'h01;
        if (inc >= cnt) begin
            ptr_next = {1'b0, st};
        end else begin
            ptr_next = inc;
        end
    endfunction

    // buffer count in dma ram for a size code; reserved acts as 32
    function automatic logic [5:0] dma_count(input logic [2:0] s);
        case (s)
            3'h0:    dma_count = 6'h04;
            3'h1:    dma_count = 6'h06;
            3'h2:    dma_count = 6'h08;
            3'h3:    dma_count = 6'h0C;
            3'h4:    dma_count = 6'h10;
            3'h5:    dma_count = 6'h18;
            default: dma_count = 6'h20;
        endcase
    endfunction

    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic        irq_ff;
    logic [4:0]  filter_count_ff;
    logic [4:0]  filter_bits_ff;
    logic [4:0]  matched_filter_number_ff;
    logic [2:0]  dma_buffer_count_sel_ff;
    logic [4:0]  fifo_start_buffer_ff;
    logic [5:0]  fifo_wr_ptr_ff;
    logic [5:0]  fifo_rd_ptr_ff;
    logic [7:0]  flags_ff;
    logic [7:0]  enables_ff;
    logic [5:0]  err_bits_ff;
    logic [3:0]  rx_buf_num_ff;
    logic [2:0]  tx_buf_num_ff;
    logic [2:0]  requested_mode_ff;
    logic [2:0]  current_mode_ff;
    logic [3:0]  idle_cnt_ff;
    can_irq_pkg::mode_state_t mode_st_ff;

    logic        wr_go;
    logic        rd_go;
    logic [5:0]  nxt_err_bits;
    logic [7:0]  flag_set;
    logic [7:0]  pending;
    logic [6:0]  code;
    logic [5:0]  buf_cnt;
    logic [31:0] rd_mux;

    // write accepted in the second request cycle, read data sampled in the first; every access has one wait
    assign wr_go   = write & ~wait_ff;
    assign rd_go   = read & wait_ff;
    assign buf_cnt = dma_count(dma_buffer_count_sel_ff);
    assign pending = flags_ff & enables_ff;

    // live error state word, warning combined from both directions
    always_comb begin
        nxt_err_bits = {err_state.tx_bus_off_state,
                        err_state.tx_error_passive_state,
                        err_state.rx_error_passive_state,
                        err_state.tx_warning_state,
                        err_state.rx_warning_state,
                        err_state.tx_warning_state
                        | err_state.rx_warning_state};
    end

    // hardware set sources for the clear-only flags
    always_comb begin
        flag_set = 8'h00;
        flag_set[`BIT_INVALID]     = events.invalid_message;
        flag_set[`BIT_WAKEUP]      = events.wakeup_activity;
        flag_set[`BIT_ERROR]       = |(nxt_err_bits & ~err_bits_ff);
        flag_set[`BIT_FIFO_FULL]   = events.fifo_almost_full;
        flag_set[`BIT_RX_OVERFLOW] = events.rx_overflow;
        flag_set[`BIT_RX_BUFFER]   = events.rx_buffer_done;
        flag_set[`BIT_TX_BUFFER]   = events.tx_buffer_done;
    end

    // fixed priority: error, overflow, wakeup, fifo, rx buf, tx buf
    always_comb begin
        if (pending[`BIT_ERROR]) begin
            code = `CODE_ERROR;
        end else if (pending[`BIT_RX_OVERFLOW]) begin
            code = `CODE_RX_OVERFLOW;
        end else if (pending[`BIT_WAKEUP]) begin
            code = `CODE_WAKEUP;
        end else if (pending[`BIT_FIFO_FULL]) begin
            code = `CODE_FIFO_FULL;
        end else if (pending[`BIT_RX_BUFFER]) begin
            code = {3'h0, rx_buf_num_ff};
        end else if (pending[`BIT_TX_BUFFER]) begin
            code = {4'h0, tx_buf_num_ff};
        end else begin
            code = `CODE_NONE;
        end
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (address == `OFS_DATA_FILTER_COUNT) begin
            rd_mux[4:0] = filter_count_ff;
        end else if (address == `OFS_INTERRUPT_CODE) begin
            rd_mux[`POS_FILTER_HIT +: 5] = matched_filter_number_ff;
            rd_mux[6:0] = code;
        end else if (address == `OFS_FIFO_CONTROL) begin
            rd_mux[`POS_DMA_SIZE +: 3] = dma_buffer_count_sel_ff;
            rd_mux[4:0] = fifo_start_buffer_ff;
        end else if (address == `OFS_FIFO_STATUS) begin
            rd_mux[`POS_WRITE_PTR +: 6] = fifo_wr_ptr_ff;
            rd_mux[5:0] = fifo_rd_ptr_ff;
        end else if (address == `OFS_INTERRUPT_FLAGS) begin
            rd_mux[13:8] = err_bits_ff;
            rd_mux[7:0]  = flags_ff;
        end else if (address == `OFS_INTERRUPT_ENABLES) begin
            rd_mux[7:0] = enables_ff;
        end else if (address == `OFS_MODE_CONTROL) begin
            rd_mux[`POS_REQ_MODE +: 3] = requested_mode_ff;
            rd_mux[`POS_CUR_MODE +: 3] = current_mode_ff;
        end
    end

    // bus handshake: waitrequest drops for exactly one cycle per access
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff <= ~((read | write) & wait_ff);
            if (rd_go) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // filter status: count sampled from filter config, hit on accept
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            filter_count_ff          <= 5'h00;
            filter_bits_ff           <= 5'h00;
            matched_filter_number_ff <= 5'h00;
        end else begin
            filter_count_ff <= filter_bit_count_in;
            // invalid codes must not widen the compare
            if (filter_bit_count_in > `FILTER_COUNT_MAX) begin
                filter_bits_ff <= 5'h00;
            end else begin
                filter_bits_ff <= filter_bit_count_in;
            end
            if (events.filter_accept
                && events.filter_number <= `FILTER_HIT_MAX) begin
                matched_filter_number_ff <= events.filter_number;
            end
        end
    end

    // fifo control: a write to byte 0 also restarts both pointers at the start
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dma_buffer_count_sel_ff <= 3'h0;
            fifo_start_buffer_ff    <= 5'h00;
            fifo_wr_ptr_ff          <= 6'h00;
            fifo_rd_ptr_ff          <= 6'h00;
        end else if (wr_go && address == `OFS_FIFO_CONTROL) begin
            if (byteenable[1]) begin
                dma_buffer_count_sel_ff <= writedata[`POS_DMA_SIZE +: 3];
            end
            if (byteenable[0]) begin
                fifo_start_buffer_ff <= writedata[4:0];
                fifo_wr_ptr_ff       <= {1'b0, writedata[4:0]};
                fifo_rd_ptr_ff       <= {1'b0, writedata[4:0]};
            end
        end else begin
            if (events.fifo_written) begin
                fifo_wr_ptr_ff <= ptr_next(fifo_wr_ptr_ff, buf_cnt,
                                           fifo_start_buffer_ff);
            end
            if (events.fifo_read) begin
                fifo_rd_ptr_ff <= ptr_next(fifo_rd_ptr_ff, buf_cnt,
                                           fifo_start_buffer_ff);
            end
        end
    end

    // flags: writing zero clears, writing one keeps, a set wins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_ff    <= 8'h00;
            err_bits_ff <= 6'h00;
        end else begin
            err_bits_ff <= nxt_err_bits;
            if (wr_go && address == `OFS_INTERRUPT_FLAGS
                && byteenable[0]) begin
                flags_ff <= ((flags_ff & writedata[7:0]) | flag_set)
                            & `FLAG_MASK;
            end else begin
                flags_ff <= (flags_ff | flag_set) & `FLAG_MASK;
            end
        end
    end

    // enables, plus buffer numbers latched for the code
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            enables_ff    <= 8'h00;
            rx_buf_num_ff <= 4'h0;
            tx_buf_num_ff <= 3'h0;
        end else begin
            if (wr_go && address == `OFS_INTERRUPT_ENABLES
                && byteenable[0]) begin
                enables_ff <= writedata[7:0] & `FLAG_MASK;
            end
            if (events.rx_buffer_done) begin
                rx_buf_num_ff <= events.buffer_number;
            end
            if (events.tx_buffer_done) begin
                tx_buf_num_ff <= events.buffer_number[2:0];
            end
        end
    end

    // irq is registered so it lags the flag by one cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |pending;
        end
    end

    // mode request waits for a run of recessive bits before it lands
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            requested_mode_ff <= `RST_MODE;
            current_mode_ff   <= `RST_MODE;
            idle_cnt_ff       <= 4'h0;
            mode_st_ff        <= can_irq_pkg::MODE_STABLE;
        end else begin
            if (bit_tick) begin
                if (!bus_recessive) begin
                    idle_cnt_ff <= 4'h0;
                end else if (idle_cnt_ff != `IDLE_BITS) begin
                    idle_cnt_ff <= idle_cnt_ff + 4'h1;
                end
            end
            case (mode_st_ff)
                can_irq_pkg::MODE_STABLE: begin
                    if (requested_mode_ff != current_mode_ff) begin
                        mode_st_ff <= can_irq_pkg::MODE_PENDING;
                    end
                end
                default: begin
                    if (idle_cnt_ff == `IDLE_BITS) begin
                        current_mode_ff <= requested_mode_ff;
                        mode_st_ff      <= can_irq_pkg::MODE_STABLE;
                    end
                end
            endcase
            if (wr_go && address == `OFS_MODE_CONTROL && byteenable[1]) begin
                requested_mode_ff <= writedata[`POS_REQ_MODE +: 3];
            end
        end
    end

    assign readdata           = rdata_ff;
    assign waitrequest        = wait_ff;
    assign irq                = irq_ff;
    assign filter_data_bits   = filter_bits_ff;
    assign fifo_write_pointer = fifo_wr_ptr_ff[4:0];
    assign current_mode       = current_mode_ff;

endmodule

`default_nettype wire

// ### can_irq_params.svh
// offsets, field positions, reset values and codes of the interrupt,
// fifo and filter-status register block.
// assumes a 32-bit avalon slave, byte addresses, one register a word.
`ifndef CAN_IRQ_PARAMS_SVH
`define CAN_IRQ_PARAMS_SVH

// register byte offsets
`define OFS_DATA_FILTER_COUNT 5'h00
`define OFS_INTERRUPT_CODE    5'h04
`define OFS_FIFO_CONTROL      5'h08
`define OFS_FIFO_STATUS       5'h0C
`define OFS_INTERRUPT_FLAGS   5'h10
`define OFS_INTERRUPT_ENABLES 5'h14
`define OFS_MODE_CONTROL      5'h18

// interrupt flag / enable bit positions
`define BIT_TX_BUS_OFF   13
`define BIT_TX_PASSIVE   12
`define BIT_RX_PASSIVE   11
`define BIT_TX_WARN      10
`define BIT_RX_WARN      9
`define BIT_ANY_WARN     8
`define BIT_INVALID      7
`define BIT_WAKEUP       6
`define BIT_ERROR        5
`define BIT_FIFO_FULL    3
`define BIT_RX_OVERFLOW  2
`define BIT_RX_BUFFER    1
`define BIT_TX_BUFFER    0
`define FLAG_MASK        8'hEF

// interrupt source codes
`define CODE_FIFO_FULL   7'h44
`define CODE_RX_OVERFLOW 7'h43
`define CODE_WAKEUP      7'h42
`define CODE_ERROR       7'h41
`define CODE_NONE        7'h40

// field limits
`define FILTER_COUNT_MAX 5'h11
`define FILTER_HIT_MAX   5'h0F
`define DMA_SIZE_RSVD    3'h7

// field positions inside the words
`define POS_FILTER_HIT   8
`define POS_DMA_SIZE     13
`define POS_WRITE_PTR    8
`define POS_REQ_MODE     8
`define POS_CUR_MODE     5

// reset values
`define RST_MODE         3'h4
`define RST_CODE         7'h40

// bus idle is this many consecutive recessive bits
`define IDLE_BITS        4'hB

`endif

// ### can_irq_pkg.sv
// types shared by the interrupt, fifo and filter-status block.
// assumes nothing of its surroundings.
package can_irq_pkg;

    // error-state levels reported by the protocol engine
    typedef struct packed {
        logic tx_bus_off_state;
        logic tx_error_passive_state;
        logic rx_error_passive_state;
        logic tx_warning_state;
        logic rx_warning_state;
    } err_state_t;

    // one-cycle event pulses from engine, filters and dma
    typedef struct packed {
        logic       invalid_message;
        logic       wakeup_activity;
        logic       fifo_almost_full;
        logic       rx_overflow;
        logic       rx_buffer_done;
        logic       tx_buffer_done;
        logic [3:0] buffer_number;
        logic       filter_accept;
        logic [4:0] filter_number;
        logic       fifo_written;
        logic       fifo_read;
    } event_t;

    // mode change tracker
    typedef enum logic [1:0] {
        MODE_STABLE  = 2'b01,
        MODE_PENDING = 2'b10
    } mode_state_t;

endpackage

// ### can_irq_fifo_status_regs_asserts.sv
// checker for the interrupt, fifo and filter-status register block.
// assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module can_irq_fifo_status_regs_asserts (
    input wire logic                 ref_clk,
    input wire logic                 reset_n,
    input wire logic [4:0]           address,
    input wire logic                 read,
    input wire logic                 write,
    input wire logic [3:0]           byteenable,
    input wire logic [31:0]          writedata,
    input wire logic [31:0]          readdata,
    input wire logic                 waitrequest,
    input wire can_irq_pkg::event_t  events,
    input wire logic [4:0]           filter_bit_count_in,
    input wire logic                 bit_tick,
    input wire logic                 bus_recessive,
    input wire logic                 irq,
    input wire logic [4:0]           filter_data_bits,
    input wire logic [4:0]           fifo_write_pointer,
    input wire logic [2:0]           current_mode
);
    logic [7:0] en_ff;
    logic [3:0] idle_ff;
    logic [1:0] cause_ff;
    logic       wr_fc;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // fifo_control write accepted in this cycle
    assign wr_fc = write && !waitrequest && (address == 5'h08);

    // shadow of the enables, so irq can be judged without internals
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) en_ff <= 8'h00;
        else if (write && !waitrequest && address == 5'h14 && byteenable[0])
            en_ff <= writedata[7:0] & 8'hEF;
    end

    // recessive ticks in a row; saturates so a long idle stays idle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) idle_ff <= 4'h0;
        else if (bit_tick && !bus_recessive) idle_ff <= 4'h0;
        else if (bit_tick && idle_ff != 4'hF) idle_ff <= idle_ff + 4'h1;
    end

    // two cycles of history, the pointer may sit behind an output stage
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) cause_ff <= 2'h0;
        else cause_ff <= {cause_ff[0], events.fifo_written | wr_fc};
    end

    a_wait_answers: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered next cycle");
    a_wait_one_low: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_filter_zero: assert property (
        (filter_bit_count_in > 5'h11) [*2] |-> filter_data_bits == 5'h00)
        else $error("invalid filter count not forced to zero");
    a_filter_pass: assert property (
        (filter_bit_count_in <= 5'h11) [*2] ##0 $stable(filter_bit_count_in)
        |-> filter_data_bits == filter_bit_count_in)
        else $error("valid filter count not passed on");
    a_irq_needs_en: assert property (
        irq |-> $past(en_ff) != 8'h00)
        else $error("irq with every enable clear");
    a_irq_follows: assert property (
        events.tx_buffer_done && en_ff[0] && !write |-> ##2 irq)
        else $error("enabled tx buffer event gave no irq");
    a_mode_idle: assert property (
        $changed(current_mode) |-> $past(idle_ff) >= 4'hB)
        else $error("mode changed before bus idle");
    a_wptr_cause: assert property (
        $changed(fifo_write_pointer) |-> cause_ff != 2'h0)
        else $error("write pointer moved without cause");
    a_flag_shape: assert property (
        read && !waitrequest && address == 5'h10 |-> readdata[31:14] == 18'h0
        && !readdata[4] && readdata[8] == (readdata[10] | readdata[9]))
        else $error("flag word malformed");
    a_code_shape: assert property (
        read && !waitrequest && address == 5'h04 |-> readdata[31:13] == 19'h0
        && !readdata[7] && readdata[12:8] <= 5'h0F && (readdata[6:0] <= 7'h0F
        || (readdata[6:0] >= 7'h40 && readdata[6:0] <= 7'h44)))
        else $error("code word malformed");
    a_ptr_range: assert property (
        read && !waitrequest && address == 5'h0C
        |-> (readdata & 32'hFFFF_E0E0) == 32'h0)
        else $error("fifo pointer out of range");
    a_unmapped_zero: assert property (
        read && !waitrequest && address > 5'h18 |-> readdata == 32'h0)
        else $error("unmapped read not zero");

    c_irq: cover property ($rose(irq));
    c_mode: cover property ($changed(current_mode));
    c_wptr: cover property ($changed(fifo_write_pointer));
endmodule

bind can_irq_fifo_status_regs can_irq_fifo_status_regs_asserts
    u_can_irq_fifo_status_regs_asserts (.*);
`default_nettype wire

// ### can_engine_model.sv
// behavioural protocol engine, filters and dma seen from the block.
// assumes the bench calls its tasks; all drives follow ref_clk edges.
`timescale 1ns/1ns
`default_nettype none
module can_engine_model (
    input wire logic                ref_clk,
    output can_irq_pkg::err_state_t err_state,
    output can_irq_pkg::event_t     events,
    output logic                    bit_tick,
    output logic                    bus_recessive
);
    // quiet bus, error-free engine at start
    initial begin
        err_state = '0;
        events = '0;
        bit_tick = 1'b0;
        bus_recessive = 1'b1;
    end

    // one-cycle event, numbers travel with their pulse
    task automatic pulse(input can_irq_pkg::event_t e);
        @(posedge ref_clk);
        events <= e;
        @(posedge ref_clk);
        events <= '0;
    endtask

    // error-state levels change on an edge and then hold
    task automatic set_err(input can_irq_pkg::err_state_t s);
        @(posedge ref_clk);
        err_state <= s;
    endtask

    // bit ticks spaced four cycles apart, level sampled on each
    task automatic ticks(input int n, input logic rec);
        repeat (n) begin
            @(posedge ref_clk);
            bit_tick <= 1'b1;
            bus_recessive <= rec;
            @(posedge ref_clk);
            bit_tick <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// ### tb_can_irq_fifo_status_regs.sv
// self-checking bench for the interrupt, fifo and filter-status block.
// assumes the engine model and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
module tb_can_irq_fifo_status_regs;
    logic                    ref_clk, reset_n, read, write, waitrequest;
    logic                    irq, bit_tick, bus_recessive;
    logic [4:0]              address, filter_bit_count_in;
    logic [4:0]              filter_data_bits, fifo_write_pointer;
    logic [3:0]              byteenable;
    logic [2:0]              current_mode;
    logic [31:0]             writedata, readdata, rd;
    can_irq_pkg::err_state_t err_state;
    can_irq_pkg::event_t     events, ev;
    int                      err_count, checks;

    can_irq_fifo_status_regs u_can_irq_fifo_status_regs (.*);
    can_engine_model u_can_engine_model (.*);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic settle;
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic t_reset;
        logic [31:0] e [8] = '{32'h0, 32'h40, 32'h0, 32'h0, 32'h0, 32'h0,
                               32'h480, 32'h0};
        chk(irq, 32'h0);
        chk(current_mode, 32'h4);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            chk(rd, e[i]);
        end
    endtask

    task automatic t_filter;
        logic [4:0] c [5] = '{5'h00, 5'h01, 5'h11, 5'h12, 5'h1F};
        logic [4:0] e [5] = '{5'h00, 5'h01, 5'h11, 5'h00, 5'h00};
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            filter_bit_count_in <= c[i];
            settle;
            chk(filter_data_bits, e[i]);
        end
    endtask

    // every source but error alone: code, flag, write-one kept, write-zero clears
    task automatic t_codes;
        int         b [8] = '{3, 2, 6, 1, 1, 0, 0, 7};
        logic [6:0] c [8] = '{7'h44, 7'h43, 7'h42, 7'h08, 7'h0F, 7'h00,
                              7'h07, 7'h40};
        bus(1'b1, 5'h14, 32'hEF);
        for (int i = 0; i < 8; i++) begin
            ev = '0;
            ev.buffer_number = c[i][3:0];
            case (i)
                0: ev.fifo_almost_full = 1'b1;
                1: ev.rx_overflow = 1'b1;
                2: ev.wakeup_activity = 1'b1;
                3, 4: ev.rx_buffer_done = 1'b1;
                5, 6: ev.tx_buffer_done = 1'b1;
                default: ev.invalid_message = 1'b1;
            endcase
            u_can_engine_model.pulse(ev);
            settle;
            chk(irq, 32'h1);
            bus(1'b0, 5'h04, 32'h0);
            chk(rd[6:0], c[i]);
            bus(1'b1, 5'h10, 32'hFF);
            bus(1'b0, 5'h10, 32'h0);
            chk(rd, 32'h1 << b[i]);
            bus(1'b1, 5'h10, ~(32'h1 << b[i]));
            bus(1'b0, 5'h10, 32'h0);
            chk(rd, 32'h0);
            chk(irq, 32'h0);
        end
        bus(1'b1, 5'h14, 32'h0);
        ev = '0;
        ev.wakeup_activity = 1'b1;
        u_can_engine_model.pulse(ev);
        settle;
        chk(irq, 32'h0);
        bus(1'b0, 5'h04, 32'h0);
        chk(rd[6:0], 7'h40);
        bus(1'b1, 5'h10, 32'hFFBF);
    endtask

    task automatic t_errors;
        logic [4:0]  s [4] = '{5'h02, 5'h03, 5'h1F, 5'h00};
        logic [31:0] e [4] = '{32'h520, 32'h720, 32'h3F20, 32'h20};
        bus(1'b1, 5'h14, 32'h20);
        for (int i = 0; i < 4; i++) begin
            u_can_engine_model.set_err(can_irq_pkg::err_state_t'(s[i]));
            settle;
            bus(1'b0, 5'h10, 32'h0);
            chk(rd, e[i]);
        end
        bus(1'b0, 5'h04, 32'h0);
        chk(rd[6:0], 7'h41);
        bus(1'b1, 5'h10, 32'hFFDF);
        bus(1'b0, 5'h10, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_hit;
        ev = '0;
        ev.filter_accept = 1'b1;
        for (int i = 0; i < 2; i++) begin
            ev.filter_number = (i == 0) ? 5'h0F : 5'h10;
            u_can_engine_model.pulse(ev);
            settle;
            bus(1'b0, 5'h04, 32'h0);
            chk(rd[12:8], 5'h0F);
        end
    endtask

    // four-buffer dma area, fifo from buffer 1 to 3: the pointer wraps after the third write
    task automatic t_fifo;
        logic [31:0] e [3] = '{32'h301, 32'h101, 32'h102};
        bus(1'b1, 5'h08, 32'h1);
        bus(1'b0, 5'h0C, 32'h0);
        chk(rd, 32'h101);
        for (int i = 0; i < 3; i++) begin
            ev = '0;
            ev.fifo_written = (i < 2);
            ev.fifo_read = (i == 2);
            if (i == 0) u_can_engine_model.pulse(ev);
            u_can_engine_model.pulse(ev);
            settle;
            bus(1'b0, 5'h0C, 32'h0);
            chk(rd, e[i]);
        end
        chk(fifo_write_pointer, 32'h1);
        bus(1'b1, 5'h08, 32'hC01F);
        bus(1'b1, 5'h0C, 32'h0);
        bus(1'b0, 5'h08, 32'h0);
        chk(rd, 32'hC01F);
        bus(1'b0, 5'h0C, 32'h0);
        chk(rd, 32'h1F1F);
    endtask

    task automatic t_mode;
        bus(1'b1, 5'h18, 32'h0);
        u_can_engine_model.ticks(1, 1'b0);
        u_can_engine_model.ticks(10, 1'b1);
        settle;
        chk(current_mode, 32'h4);
        u_can_engine_model.ticks(1, 1'b1);
        settle;
        chk(current_mode, 32'h0);
        bus(1'b0, 5'h18, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic results;
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence; byteenable stays all lanes
    initial begin
        reset_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        byteenable = 4'hF;
        writedata = 32'h0;
        filter_bit_count_in = 5'h00;
        err_count = 0;
        checks = 0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset;
        t_filter;
        t_codes;
        t_errors;
        t_hit;
        t_fifo;
        t_mode;
        results;
    end

    // the whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        results;
    end
endmodule
`default_nettype wire
